// ===== rtl/fhi_iface.sv
/*
  Host I/O-instruction interface with a behavioural controller engine and
  an AHB-Lite register slave. Assumes io_req comes from logic on hclk and
  that dev_switch and bus_init are asynchronous pins.
*/
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
module fhi_iface #(
  parameter int unsigned PACE12_CYCLES = fhi_pkg::PACE12_CYC,
  parameter int unsigned PACE8_CYCLES  = fhi_pkg::PACE8_CYC,
  parameter int unsigned INIT_CYCLES   = fhi_pkg::INIT_CYC
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic [2:0]           dev_switch,
  input  wire logic                 bus_init,
  input  wire fhi_pkg::fhi_io_req_t io_req,
  output fhi_pkg::fhi_io_rsp_t      io_rsp,
  output logic                      cpu_irq,
  output logic                      drive_sel
);
  import fhi_pkg::*;

  function automatic logic [8:0] cap_of(input logic mode8, input logic double_recording_bit);
    if (mode8) begin
      cap_of = double_recording_bit ? CAP8_DD : CAP8_SD;
    end else begin
      cap_of = double_recording_bit ? CAP12_DD : CAP12_SD;
    end
  endfunction

  // Pin synchronisers
  logic [2:0] sw_meta;
  logic [2:0] sw_sync;
  logic       init_meta;
  logic       init_sync;
  logic       init_prev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_meta   <= 3'h0;
      sw_sync   <= 3'h0;
      init_meta <= 1'b0;
      init_sync <= 1'b0;
      init_prev <= 1'b0;
    end else begin
      sw_meta   <= dev_switch;
      sw_sync   <= sw_meta;
      init_meta <= bus_init;
      init_sync <= init_meta;
      init_prev <= init_sync;
    end
  end

  // State
  fhi_state_t  state;
  fhi_state_t  next_state;
  fhi_func_t   func;
  fhi_func_t   next_func;
  logic [11:0] ireg;
  logic [11:0] next_ireg;
  logic [11:0] esw;
  logic [11:0] next_esw;
  logic [7:0]  err_code;
  logic [7:0]  next_err_code;
  logic [8:0]  idx;
  logic [8:0]  next_idx;
  logic [8:0]  need;
  logic [8:0]  next_need;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic        dir_out;
  logic        next_dir_out;
  logic        mode8;
  logic        next_mode8;
  logic        drive;
  logic        next_drive;
  logic        cmd_den;
  logic        next_cmd_den;
  logic [1:0]  double_recording_bit;
  logic [1:0]  next_den;
  logic [11:0] trk_sec;
  logic [11:0] next_trk_sec;
  logic [7:0]  cmd_lo;
  logic [7:0]  next_cmd_lo;
  logic        ww_flag;
  logic        fault_flag;
  logic        fin_flag;
  logic        ie;
  logic        next_ie;
  logic        ww_set;
  logic        fin_set;
  logic        fault_set;
  logic        init_clr;
  logic        buf_we;
  logic [7:0]  buf_waddr;
  logic [11:0] buf_wdata;
  logic [11:0] sect_buf [BUF_DEPTH];

  // Instruction decode
  wire logic    dev_hit = io_req.valid && io_req.instr[11:9] == IOT_GROUP
                          && io_req.instr[8:6] == DEV_HIGH && io_req.instr[5:3] == sw_sync;
  wire fhi_op_t op      = fhi_op_t'(io_req.instr[2:0]);
  wire logic    do_load = dev_hit && op == OP_LOAD;
  wire logic    do_xfer = dev_hit && op == OP_XFER;
  wire logic    do_str  = dev_hit && op == OP_SKIP_WW;
  wire logic    do_ser  = dev_hit && op == OP_SKIP_FAULT;
  wire logic    do_sdn  = dev_hit && op == OP_SKIP_FIN;
  wire logic    do_ien  = dev_hit && op == OP_IRQ_EN;
  wire logic    do_init = (dev_hit && op == OP_INIT) || (init_sync && !init_prev);

  // Bus slave decode
  logic        ap_write;
  logic [7:0]  ap_addr;
  wire  logic  ap_take   = hsel && hready && htrans[1];
  wire  logic  fault_wr  = ap_write && ap_addr == REG_FAULT && hwdata[7:0] != 8'h00;
  wire  logic [31:0] status_word = {4'h0, sw_sync, 1'b0, idx[7:0], 1'b0, state, func, double_recording_bit,
                                    dir_out, drive, mode8, ie, fin_flag, fault_flag, ww_flag};
  wire  logic [31:0] rd_mux = (haddr[7:0] == REG_FAULT)  ? {24'h0, err_code} :
                              (haddr[7:0] == REG_STATUS) ? status_word :
                              (haddr[7:0] == REG_ESW)    ? {20'h0, esw} : 32'h0;

  wire logic [31:0] pace_cyc = mode8 ? 32'(PACE8_CYCLES) : 32'(PACE12_CYCLES);
  wire logic [11:0] cmd_word = (state == S_CMD2) ?
                               {2'b00, io_req.ac[0], io_req.ac[1], cmd_lo} : io_req.ac;
  wire fhi_func_t   cmd_fn   = fhi_func_t'(cmd_word[CMD_FUNC_LSB +: 3]);
  wire logic        waiting  = state == S_WAIT;
  wire logic        to_host  = do_xfer && (state == S_IDLE || (waiting && dir_out));
  wire logic [11:0] to_ac    = mode8 ? {io_req.ac[11:8], io_req.ac[7:0] | ireg[7:0]} : ireg;

  always_comb begin
    next_state    = state;
    next_func     = func;
    next_ireg     = ireg;
    next_esw      = esw;
    next_err_code = err_code;
    next_idx      = idx;
    next_need     = need;
    next_timer    = timer;
    next_dir_out  = dir_out;
    next_mode8    = mode8;
    next_drive    = drive;
    next_cmd_den  = cmd_den;
    next_den      = double_recording_bit;
    next_trk_sec  = trk_sec;
    next_cmd_lo   = cmd_lo;
    next_ie       = do_ien ? io_req.ac[AC_IE_BIT] : ie;
    ww_set        = 1'b0;
    fin_set       = 1'b0;
    fault_set     = 1'b0;
    init_clr      = 1'b0;
    buf_we        = 1'b0;
    buf_waddr     = idx[7:0];
    buf_wdata     = 12'h000;
    if (do_init) begin
      init_clr   = 1'b1;
      next_ie    = 1'b0;
      next_esw   = 12'h000;
      next_mode8 = MODE8_RST;
      next_func  = FN_READ;
      next_timer = 32'(INIT_CYCLES);
      next_state = S_RUN;
    end else if (fault_wr) begin
      fault_set     = 1'b1;
      fin_set       = 1'b1;
      next_err_code = hwdata[7:0];
      next_esw[ESW_FAULT] = 1'b1;
      next_ireg     = esw | (12'h001 << ESW_FAULT);
      next_state    = S_IDLE;
    end else begin
      unique case (state)
        S_IDLE, S_CMD2: begin
          if (do_load && state == S_IDLE && io_req.ac[CMD_MODE8]) begin
            next_cmd_lo = io_req.ac[7:0];
            next_ireg   = io_req.ac;
            next_mode8  = 1'b1;
            ww_set      = 1'b1;
            next_state  = S_CMD2;
          end else if ((do_load && state == S_IDLE) || (do_xfer && state == S_CMD2)) begin
            next_ireg    = cmd_word;
            next_func    = cmd_fn;
            next_mode8   = cmd_word[CMD_MODE8];
            next_drive   = cmd_word[CMD_DRV];
            next_cmd_den = cmd_word[CMD_DEN];
            next_idx     = 9'h000;
            unique case (cmd_fn)
              FN_FILL, FN_EMPTY: begin
                next_need    = cap_of(cmd_word[CMD_MODE8], cmd_word[CMD_DEN]);
                next_dir_out = cmd_fn == FN_EMPTY;
                next_state   = S_REQ;
              end
              FN_WRITE, FN_READ, FN_WRITE_DEL: begin
                next_need    = ADDR_WORDS;
                next_dir_out = 1'b0;
                next_state   = S_REQ;
              end
              FN_SET_DEN: begin
                next_den[cmd_word[CMD_DRV]] = cmd_word[CMD_DEN];
                next_ireg  = esw;
                fin_set    = 1'b1;
                next_state = S_IDLE;
              end
              FN_READ_STAT: begin
                next_ireg  = esw;
                fin_set    = 1'b1;
                next_state = S_IDLE;
              end
              FN_READ_ERR: begin
                next_ireg  = {4'h0, err_code};
                fin_set    = 1'b1;
                next_state = S_IDLE;
              end
            endcase
          end
        end
        S_REQ: begin
          if (dir_out) begin
            next_ireg = mode8 ? {4'h0, sect_buf[idx[7:0]][7:0]} : sect_buf[idx[7:0]];
          end
          ww_set     = 1'b1;
          next_state = S_WAIT;
        end
        S_WAIT: begin
          if (do_xfer) begin
            if (!dir_out) begin
              next_ireg = io_req.ac;
              if (func == FN_FILL) begin
                buf_we    = 1'b1;
                buf_wdata = mode8 ? {4'h0, io_req.ac[7:0]} : io_req.ac;
              end else if (idx == 9'h000) begin
                next_trk_sec[11:6] = io_req.ac[5:0];
              end else begin
                next_trk_sec[5:0] = io_req.ac[5:0];
              end
            end
            next_idx = idx + 9'h001;
            if (idx + 9'h001 != need) begin
              next_timer = pace_cyc;
              next_state = S_PACE;
            end else if (func == FN_FILL && !mode8) begin
              next_state = S_PAD;
            end else if (func == FN_FILL || func == FN_EMPTY) begin
              next_ireg  = esw;
              fin_set    = 1'b1;
              next_state = S_IDLE;
            end else begin
              next_timer = pace_cyc;
              next_state = S_RUN;
            end
          end
        end
        S_PACE: begin
          next_timer = timer - 32'h1;
          if (timer <= 32'h1) begin
            next_state = S_REQ;
          end
        end
        S_PAD: begin
          buf_we   = 1'b1;
          next_idx = idx + 9'h001;
          if (idx[7:0] == 8'hff) begin
            next_ireg  = esw;
            fin_set    = 1'b1;
            next_state = S_IDLE;
          end
        end
        S_RUN: begin
          next_timer = timer - 32'h1;
          if (timer <= 32'h1) begin
            if (func == FN_WRITE_DEL) begin
              next_esw[1] = 1'b1;
            end
            if (func == FN_READ && !(|need)) begin
              next_esw[ESW_INIT_DONE] = 1'b1;
            end
            next_ireg  = next_esw;
            fin_set    = 1'b1;
            next_state = S_IDLE;
          end
        end
        default: begin
          next_state = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state    <= S_IDLE;
      func     <= FN_FILL;
      ireg     <= 12'h000;
      esw      <= 12'h000;
      err_code <= 8'h00;
      idx      <= 9'h000;
      need     <= 9'h000;
      timer    <= 32'h0;
      dir_out  <= 1'b0;
      mode8    <= MODE8_RST;
      drive    <= 1'b0;
      cmd_den  <= 1'b0;
      double_recording_bit      <= DEN_RST;
      trk_sec  <= 12'h000;
      cmd_lo   <= 8'h00;
      ie       <= 1'b0;
    end else begin
      state    <= next_state;
      func     <= next_func;
      ireg     <= next_ireg;
      esw      <= next_esw;
      err_code <= next_err_code;
      idx      <= next_idx;
      need     <= do_init ? 9'h000 : next_need;
      timer    <= next_timer;
      dir_out  <= next_dir_out;
      mode8    <= next_mode8;
      drive    <= next_drive;
      cmd_den  <= next_cmd_den;
      double_recording_bit      <= next_den;
      trk_sec  <= next_trk_sec;
      cmd_lo   <= next_cmd_lo;
      ie       <= next_ie;
    end
  end

  // Flags: a set in the same cycle as a skip clear wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ww_flag    <= 1'b0;
      fault_flag <= 1'b0;
      fin_flag   <= 1'b0;
    end else if (init_clr) begin
      ww_flag    <= 1'b0;
      fault_flag <= 1'b0;
      fin_flag   <= 1'b0;
    end else begin
      ww_flag    <= ww_set | (ww_flag & ~do_str);
      fault_flag <= fault_set | (fault_flag & ~do_ser);
      fin_flag   <= fin_set | (fin_flag & ~do_sdn);
    end
  end

  always_ff @(posedge hclk) begin
    if (buf_we) begin
      sect_buf[buf_waddr] <= buf_wdata;
    end
  end

  // Answer to the CPU one cycle after the instruction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_rsp <= '0;
    end else begin
      io_rsp.valid    <= dev_hit;
      io_rsp.skip     <= (do_str && ww_flag) || (do_ser && fault_flag) || (do_sdn && fin_flag);
      io_rsp.ac_write <= (do_load && (state == S_IDLE)) || to_host;
      io_rsp.ac       <= to_host ? to_ac : 12'h000;
    end
  end

  // Bus slave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
      hrdata   <= 32'h0;
    end else begin
      ap_write <= ap_take && hwrite;
      ap_addr  <= haddr[7:0];
      hrdata   <= (ap_take && !hwrite) ? rd_mux : 32'h0;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign cpu_irq   = fin_flag && ie;
  assign drive_sel = drive;

endmodule

// ===== rtl/fhi_pkg.sv
/*
  Shared constants, enumerations and carriers of the floppy host
  I/O-instruction interface. Assumes a single 100 MHz clock domain.
*/
package fhi_pkg;

  // Timing
  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned PACE12_MS  = 23;
  localparam int unsigned PACE8_MS   = 18;
  localparam real         INIT_S     = 1.8;
  localparam int unsigned PACE12_CYC = PACE12_MS * (CLK_HZ / 1000);
  localparam int unsigned PACE8_CYC  = PACE8_MS * (CLK_HZ / 1000);
  localparam int unsigned INIT_CYC   = int'(INIT_S * CLK_HZ);

  // I/O instruction layout, bit 0 of the word being the rightmost bit
  localparam logic [2:0] IOT_GROUP  = 3'h6;
  localparam logic [2:0] DEV_HIGH   = 3'h7;
  localparam int         AC_IE_BIT  = 0;

  // Command word field positions
  localparam int CMD_FUNC_LSB = 1;
  localparam int CMD_DRV      = 4;
  localparam int CMD_MODE8    = 6;
  localparam int CMD_DEN      = 8;

  // Error and status word bits
  localparam int ESW_FAULT     = 0;
  localparam int ESW_INIT_DONE = 2;

  // Reset values
  localparam logic       MODE8_RST = 1'b0;
  localparam logic [1:0] DEN_RST   = 2'b00;

  // Sector capacity in transfers
  localparam logic [8:0] CAP12_SD = 9'h040;
  localparam logic [8:0] CAP12_DD = 9'h080;
  localparam logic [8:0] CAP8_SD  = 9'h080;
  localparam logic [8:0] CAP8_DD  = 9'h100;
  localparam logic [8:0] ADDR_WORDS = 9'h002;
  localparam int         BUF_DEPTH  = 256;

  // Register offsets on the bus
  localparam logic [7:0] REG_FAULT  = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ESW    = 8'h08;

  typedef enum logic [2:0] {
    OP_NOP, OP_LOAD, OP_XFER, OP_SKIP_WW, OP_SKIP_FAULT, OP_SKIP_FIN, OP_IRQ_EN, OP_INIT
  } fhi_op_t;

  typedef enum logic [2:0] {
    FN_FILL, FN_EMPTY, FN_WRITE, FN_READ, FN_SET_DEN, FN_READ_STAT, FN_WRITE_DEL, FN_READ_ERR
  } fhi_func_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CMD2 = 3'b001,
    S_REQ  = 3'b011,
    S_WAIT = 3'b010,
    S_PACE = 3'b110,
    S_PAD  = 3'b111,
    S_RUN  = 3'b101
  } fhi_state_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] instr;
    logic [11:0] ac;
  } fhi_io_req_t;

  typedef struct packed {
    logic        valid;
    logic        skip;
    logic        ac_write;
    logic [11:0] ac;
  } fhi_io_rsp_t;

endpackage

// ===== verif/fhi_host_model.sv
/*
  Host processor model issuing one I/O instruction at a time.
  Assumes the answer comes one cycle after a matched instruction.
*/
`timescale 1ns/1ns
module fhi_host_model (
  input  wire logic                 hclk,
  input  wire fhi_pkg::fhi_io_rsp_t io_rsp,
  output fhi_pkg::fhi_io_req_t      io_req
);
  import fhi_pkg::*;
  initial io_req = '0;

  // Released lines carry the inverse so stale values are never seen
  task automatic issue(input logic [2:0] op, input logic [2:0] dig, input logic [11:0] ac,
                       output fhi_io_rsp_t rsp);
    @(posedge hclk);
    io_req <= '{valid: 1'b1, instr: {IOT_GROUP, DEV_HIGH, dig, op}, ac: ac};
    @(posedge hclk);
    io_req <= '{valid: 1'b0, instr: ~{IOT_GROUP, DEV_HIGH, dig, op}, ac: ~ac};
    @(posedge hclk);
    rsp = io_rsp;
  endtask
endmodule

// ===== verif/fhi_iface_asserts.sv
/*
  Port checker for fhi_iface, bound onto the top module.
  Assumes one clock domain and the device code synchroniser of two stages.
*/
`timescale 1ns/1ns
module fhi_iface_chk (
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hsel,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic                 hready,
  input wire logic [31:0]          hrdata,
  input wire logic [2:0]           dev_switch,
  input wire fhi_pkg::fhi_io_req_t io_req,
  input wire fhi_pkg::fhi_io_rsp_t io_rsp,
  input wire logic                 cpu_irq
);
  import fhi_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire [2:0] op = io_req.instr[2:0];

  rsp_cause_a: assert property (io_rsp.valid |-> $past(io_req.valid) && $past(io_req.instr[11:6]) == 6'h37)
    else $error("answer without a matching instruction");
  foreign_code_a: assert property (io_req.valid && io_req.instr[5:3] != dev_switch && $stable(dev_switch)
    && $past(dev_switch, 2) == dev_switch |=> !io_rsp.valid)
    else $error("answer to another device code");
  load_clear_a: assert property (io_rsp.valid && io_rsp.ac_write && $past(op) == OP_LOAD |-> io_rsp.ac == 12'h000)
    else $error("load command left the working register");
  ie_off_a: assert property (io_rsp.valid && $past(op) == OP_IRQ_EN && !$past(io_req.ac[0]) |-> !cpu_irq)
    else $error("interrupt after disable");
  skip_source_a: assert property (io_rsp.valid && io_rsp.skip |-> $past(op) inside {OP_SKIP_WW, OP_SKIP_FAULT, OP_SKIP_FIN})
    else $error("skip from a non-skip operation");
  skip_clear_a: assert property (io_req.valid && op inside {OP_SKIP_WW, OP_SKIP_FAULT, OP_SKIP_FIN} ##1 io_rsp.valid
    && io_rsp.skip ##2 io_req.valid && io_req.instr == $past(io_req.instr, 3) |=> io_rsp.valid && !io_rsp.skip)
    else $error("skip flag not cleared");
  fin_irq_a: assert property (io_rsp.valid && io_rsp.skip && $past(op) == OP_SKIP_FIN |-> !cpu_irq)
    else $error("interrupt after finished flag cleared");
  idle_rdata_a: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0)
    else $error("read data outside data phase");
endmodule

bind fhi_iface fhi_iface_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .dev_switch(dev_switch), .io_req(io_req),
  .io_rsp(io_rsp), .cpu_irq(cpu_irq));

// ===== verif/fhi_iface_bench.sv
/*
  Self-checking bench for fhi_iface with a host model and an AHB-Lite master.
  Assumes shortened pacing and initialize counts.
*/
`timescale 1ns/1ns
module fhi_iface_bench;
  import fhi_pkg::*;
  localparam int P12 = 20;
  localparam int P8  = 16;
  localparam int PI  = 50;
  logic        hclk, hresetn, hsel, hwrite, bus_init, hreadyout, hresp, cpu_irq, drive_sel;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, dev_switch, dig;
  logic [11:0] got [0:129];
  fhi_io_req_t io_req;
  fhi_io_rsp_t io_rsp, r;
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;

  fhi_iface #(.PACE12_CYCLES(P12), .PACE8_CYCLES(P8), .INIT_CYCLES(PI)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .dev_switch(dev_switch), .bus_init(bus_init), .io_req(io_req), .io_rsp(io_rsp),
    .cpu_irq(cpu_irq), .drive_sel(drive_sel));
  fhi_host_model host (.hclk(hclk), .io_rsp(io_rsp), .io_req(io_req));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic io(input logic [2:0] op, input logic [11:0] ac);
    host.issue(op, dig, ac, r);
  endtask

  // Loads a command, then serves word requests until finished
  task automatic run_fn(input logic [11:0] cmd, input logic [11:0] base, input logic step, input int pace,
                        output int n);
    int t;
    n = 0;
    t = 0;
    io(OP_LOAD, cmd);
    check(r.ac_write && r.ac == 12'h000, 1);
    repeat (3000) begin
      io(OP_SKIP_FIN, 12'h000);
      if (r.skip === 1'b1 || n > 129) break;
      io(OP_SKIP_WW, 12'h000);
      if (r.skip === 1'b1) begin
        if (n > 1) check(cyc - t >= pace && cyc - t <= pace + 12, 1);
        if (n == 0) begin
          io(OP_SKIP_WW, 12'h000);
          check(r.skip, 0);
        end
        if (n == 5) begin
          io(OP_LOAD, 12'h00a);
          check(r.ac_write, 0);
        end
        if (n == 10) repeat (100) @(posedge hclk);
        io(OP_XFER, n == 0 ? 12'h000 : base + (step ? n[11:0] : 12'h000));
        check(r.ac_write, !step && (n > 0 || !cmd[6]));
        got[n] = r.ac;
        n++;
        t = cyc;
      end
    end
  endtask

  task automatic t_reset();
    logic [31:0] d;
    ahb(1'b0, REG_STATUS, 32'h0, d);
    check(d[4:0], 5'h00);
    ahb(1'b0, 8'h40, 32'h0, d);
    check(d, 32'h0);
  endtask

  task automatic t_devcode();
    for (int d = 0; d < 8; d++) begin
      dev_switch <= d[2:0];
      repeat (4) @(posedge hclk);
      dig = d[2:0];
      io(OP_NOP, 12'h000);
      check(r.valid, 1);
      dig = d[2:0] ^ 3'h1;
      io(OP_NOP, 12'h000);
      check(r.valid, 0);
    end
    dig = 3'h7;
  endtask

  task automatic t_word12();
    int n;
    run_fn(12'h000, 12'h700, 1'b1, P12, n);
    check(n, 64);
    run_fn(12'h002, 12'h5a5, 1'b0, P12, n);
    check(n, 64);
    for (int i = 0; i < 64; i++) check(got[i], i == 0 ? 0 : 12'h700 + i);
  endtask

  task automatic t_funcs();
    int n;
    for (int f = 2; f < 8; f++) begin
      run_fn({7'h0, f[0], f[2:0], 1'b0}, 12'h001, 1'b1, P12, n);
      check(n, (f == 2 || f == 3 || f == 6) ? 2 : 0);
      check(drive_sel, f[0]);
    end
  endtask

  task automatic t_byte8();
    int n;
    logic [31:0] d;
    run_fn(12'h040, 12'h000, 1'b1, P8, n);
    check(n, 129);
    ahb(1'b0, REG_STATUS, 32'h0, d);
    check(d[4], 1);
    run_fn(12'h042, 12'ha40, 1'b0, P8, n);
    check(n, 129);
    for (int i = 1; i < 129; i++) check(got[i], 12'ha40 | i);
  endtask

  task automatic t_init(input logic by_pin);
    int t0;
    logic [31:0] d;
    t0 = cyc;
    if (by_pin) begin
      bus_init <= 1'b1;
      repeat (4) @(posedge hclk);
      bus_init <= 1'b0;
    end else io(OP_INIT, 12'h000);
    repeat (200) begin
      io(OP_SKIP_FIN, 12'h000);
      if (r.skip === 1'b1) break;
    end
    check({r.skip, cyc - t0 <= PI + 16}, 2'b11);
    ahb(1'b0, REG_ESW, 32'h0, d);
    check({d[2], d[0]}, 2'b10);
    ahb(1'b0, REG_STATUS, 32'h0, d);
    check(d[4:3], 2'b00);
    io(OP_XFER, 12'h000);
    check({r.ac_write, r.ac[2]}, 2'b11);
  endtask

  task automatic t_fault();
    logic [31:0] d;
    io(OP_IRQ_EN, 12'h001);
    ahb(1'b1, REG_FAULT, 32'h05, d);
    repeat (2) @(posedge hclk);
    check(cpu_irq, 1);
    io(OP_SKIP_FAULT, 12'h000);
    check(r.skip, 1);
    io(OP_SKIP_FAULT, 12'h000);
    check(r.skip, 0);
    io(OP_IRQ_EN, 12'h000);
    check(cpu_irq, 0);
    io(OP_IRQ_EN, 12'h001);
    check(cpu_irq, 1);
    io(OP_SKIP_FIN, 12'h000);
    check({r.skip, cpu_irq}, 2'b10);
    ahb(1'b0, REG_FAULT, 32'h0, d);
    check(d[7:0], 8'h05);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    dev_switch = 3'h0;
    bus_init = 1'b0;
    dig = 3'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_devcode();
    t_word12();
    t_funcs();
    t_byte8();
    t_init(1'b0);
    t_init(1'b1);
    t_fault();
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    end_of_test();
  end

  initial begin
    #900000;
    fail_count++;
    end_of_test();
  end
endmodule
